// ==== speed_monitor_fault_supervisor.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "fault_supervisor_params.svh"
module speed_monitor_fault_supervisor
  import fault_supervisor_pkg::*;
#(
  parameter int unsigned DEV_CYCLES = `DEV_CYCLES,
  parameter int unsigned STOP_CYCLES = `STOP_CYCLES
) (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic [5:0] i_track_ok,
  input wire logic i_prox_a_valid,
  input wire logic i_prox_b_valid,
  input wire logic i_freq_out_of_tol,
  input wire logic i_above_standstill,
  input wire logic i_start_input_terminal,
  input wire logic i_startup_ok,
  input wire logic [1:0] i_range_ok,
  input wire logic [1:0] i_image_local,
  input wire logic [1:0] i_image_partner,
  input wire logic i_root_cmd,
  input wire logic i_root_fb,
  input wire logic i_relay_output_one_fb,
  input wire logic i_relay_output_two_fb,
  input wire logic i_relay_output_one_cmd,
  input wire logic i_relay_output_two_cmd,
  input wire logic i_supply_vcc_fail,
  input wire logic i_supply_mid_fail,
  input wire logic i_sync_start_sel,
  input wire logic i_analog_out_en,
  input wire logic i_error_out_fn,
  input wire logic i_volt_fault,
  input wire logic [7:0] i_volt_mv_code,
  output logic o_fault_led,
  output logic o_freq_warning,
  output logic o_outputs_enable,
  output logic [1:0] o_range_ok,
  output logic [15:0] o_error_code,
  output logic o_follow_on,
  output logic [7:0] o_error_param_high,
  output logic [7:0] o_error_param_low,
  output logic [15:0] o_track_mv
);
  // two-flop synchronisers for pin inputs
  logic [11:0] sync1;
  logic [11:0] sync2;
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      sync1 <= 12'h000;
      sync2 <= 12'h000;
    end else begin
      sync1 <= {i_root_fb, i_relay_output_one_fb, i_relay_output_two_fb,
                i_start_input_terminal, i_prox_a_valid, i_prox_b_valid,
                i_track_ok};
      sync2 <= sync1;
    end
  end
  logic [5:0] track_ok;
  logic prox_b, prox_a, start_in, relay_output_two_fb, relay_output_one_fb, root_fb;
  assign track_ok = sync2[5:0];
  assign prox_b = sync2[6];
  assign prox_a = sync2[7];
  assign start_in = sync2[8];
  assign relay_output_two_fb = sync2[9];
  assign relay_output_one_fb = sync2[10];
  assign root_fb = sync2[11];

  logic start_prev;
  logic start_fall;
  assign start_fall = start_prev && !start_in;

  logic both_valid;
  assign both_valid = prox_a && prox_b;

  // open circuit on any track
  logic open_circuit;
  assign open_circuit = ~&track_ok;

  logic dev_expired, stop_expired, stop_cond, dev_cond;
  assign dev_cond = i_freq_out_of_tol && !both_valid;
  assign stop_cond = dev_cond && !i_above_standstill;
  persist_timer #(.LIMIT(DEV_CYCLES)) u_dev_timer (
    .i_ref_clk(i_ref_clk),
    .i_rst(i_rst),
    .i_cond(i_freq_out_of_tol),
    .o_expired(dev_expired)
  );
  persist_timer #(.LIMIT(STOP_CYCLES)) u_stop_timer (
    .i_ref_clk(i_ref_clk),
    .i_rst(i_rst),
    .i_cond(stop_cond),
    .o_expired(stop_expired)
  );

  logic warn, next_warn;
  logic freq_stop, next_freq_stop;
  always_comb begin
    next_warn = warn;
    if (dev_expired) begin
      next_warn = 1'b1;
    end else if (both_valid) begin
      next_warn = 1'b0;
    end
    next_freq_stop = freq_stop;
    if (stop_expired) begin
      next_freq_stop = 1'b1;
    end else if ((both_valid && i_above_standstill) || start_fall) begin
      next_freq_stop = 1'b0;
    end
  end

  logic image_err, root_err, relay_output_one_err, relay_output_two_err, sync_err;
  assign image_err = i_image_local != i_image_partner;
  assign root_err = root_fb != i_root_cmd;
  assign relay_output_one_err = relay_output_one_fb != i_relay_output_one_cmd;
  assign relay_output_two_err = relay_output_two_fb != i_relay_output_two_cmd;
  assign sync_err = i_sync_start_sel && (i_analog_out_en || i_error_out_fn);

  logic hard_fault;
  assign hard_fault = open_circuit || freq_stop || image_err || root_err ||
                      relay_output_one_err || relay_output_two_err || i_supply_vcc_fail ||
                      i_supply_mid_fail || sync_err;

  // error code priority encoder
  err_code_t code;
  always_comb begin
    if (i_supply_vcc_fail) begin
      code = `ERR_SUPPLY_VCC;
    end else if (i_supply_mid_fail) begin
      code = `ERR_SUPPLY_MID;
    end else if (image_err) begin
      code = `ERR_IMAGE;
    end else if (root_err) begin
      code = `ERR_ROOT_RELAY;
    end else if (relay_output_one_err) begin
      code = `ERR_RELAY_ONE;
    end else if (relay_output_two_err) begin
      code = `ERR_RELAY_TWO;
    end else if (sync_err) begin
      code = `ERR_SYNC_CONFLICT;
    end else if (freq_stop) begin
      code = `ERR_FREQ_STOP;
    end else if (open_circuit) begin
      code = `ERR_SIGNAL;
    end else begin
      code = `ERR_NONE;
    end
  end

  run_state_e state, next_state;
  always_comb begin
    case (state)
      ST_RUN: next_state = hard_fault ? ST_STOP : ST_RUN;
      ST_STOP: next_state = hard_fault ? ST_STOP : ST_WAIT;
      ST_WAIT: begin
        if (hard_fault) begin
          next_state = ST_STOP;
        end else if (i_startup_ok) begin
          next_state = ST_RUN;
        end else begin
          next_state = ST_WAIT;
        end
      end
      default: next_state = ST_STOP;
    endcase
  end

  // track voltage from error parameters
  logic [31:0] mv;
  always_comb begin
    if ({o_error_param_high, o_error_param_low} > `VOLT_OFFSET) begin
      mv = (({16'h0000, o_error_param_high, o_error_param_low} -
             32'h0000_00AA) * `VOLT_NUM) / `VOLT_DEN;
    end else begin
      mv = 32'h0000_0000;
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      state <= ST_STOP;
      warn <= 1'b0;
      freq_stop <= 1'b0;
      start_prev <= 1'b0;
      o_error_code <= `ERR_NONE;
      o_follow_on <= 1'b0;
      o_error_param_high <= 8'h00;
      o_error_param_low <= 8'h00;
      o_track_mv <= 16'h0000;
    end else begin
      state <= next_state;
      warn <= next_warn;
      freq_stop <= next_freq_stop;
      start_prev <= start_in;
      o_error_code <= code;
      o_follow_on <= hard_fault && (code != `ERR_NONE);
      if (i_volt_fault) begin
        o_error_param_high <= 8'h00;
        o_error_param_low <= i_volt_mv_code;
      end
      o_track_mv <= mv[15:0];
    end
  end

  assign o_freq_warning = warn;
  assign o_fault_led = warn || hard_fault || (state == ST_STOP);
  assign o_outputs_enable = (state == ST_RUN) && !hard_fault;
  assign o_range_ok = warn ? 2'b00 : i_range_ok;

  fault_off_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    open_circuit |-> !o_outputs_enable) else $error("outputs on in fault");
  code_hold_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (open_circuit && !i_supply_vcc_fail && !i_supply_mid_fail && !image_err
     && !root_err && !relay_output_one_err && !relay_output_two_err && !sync_err && !freq_stop)
    |=> (o_error_code == `ERR_SIGNAL)) else $error("signal code lost");
  restart_gate_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    ($rose(o_outputs_enable)) |-> $past(i_startup_ok))
    else $error("restart without start-up");
  warn_range_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    o_freq_warning |-> (o_range_ok == 2'b00)) else $error("range not failed");
  warn_clear_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (both_valid && !dev_expired) |=> !o_freq_warning)
    else $error("warning stuck");
  stop_off_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    freq_stop |-> !o_outputs_enable) else $error("6000 outputs on");
  stop_clear_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (freq_stop && start_fall && !stop_expired) |=> !freq_stop)
    else $error("6000 not cleared");
  vcc_code_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    i_supply_vcc_fail |=> (o_error_code == `ERR_SUPPLY_VCC))
    else $error("supply code wrong");
  empty_code_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (o_error_code == `ERR_NONE) |-> !o_follow_on)
    else $error("follow-on alone");
  led_or_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (o_freq_warning || hard_fault) |-> o_fault_led)
    else $error("lamp dark in fault");
endmodule : speed_monitor_fault_supervisor
`default_nettype wire

// ==== fault_supervisor_params.svh ====
`ifndef FAULT_SUPERVISOR_PARAMS_SVH
`define FAULT_SUPERVISOR_PARAMS_SVH
`define ERR_FREQ_STOP 16'h1770
`define ERR_IMAGE 16'h7D03
`define ERR_ROOT_RELAY 16'h7D04
`define ERR_RELAY_ONE 16'h7D05
`define ERR_RELAY_TWO 16'h7D06
`define ERR_SUPPLY_VCC 16'h7929
`define ERR_SUPPLY_MID 16'h7928
`define ERR_SYNC_CONFLICT 16'h88E3
`define ERR_STOP_FOLLOW 16'hA0FF
`define ERR_SIGNAL 16'h2814
`define ERR_NONE 16'hFFFF
`define VOLT_OFFSET 16'h00AA
`define VOLT_NUM 32'h0000_2710
`define VOLT_DEN 32'h0000_04B4
`define DEV_TIME_US 1000
`define DEV_CYCLES (`DEV_TIME_US * 100)
`define STOP_TIME_US 10000
`define STOP_CYCLES (`STOP_TIME_US * 100)
`endif

// ==== fault_supervisor_pkg.sv ====
package fault_supervisor_pkg;
  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_STOP = 2'b01,
    ST_WAIT = 2'b11
  } run_state_e;
  typedef logic [15:0] err_code_t;
endpackage : fault_supervisor_pkg

// ==== persist_timer.sv ====
`timescale 1ns/1ps
`default_nettype none
module persist_timer #(
  parameter int unsigned LIMIT = 100000
) (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_cond,
  output logic o_expired
);
  logic [31:0] count;
  logic [31:0] next_count;
  always_comb begin
    if (!i_cond) begin
      next_count = 32'h0000_0000;
    end else if (count < LIMIT) begin
      next_count = count + 32'h0000_0001;
    end else begin
      next_count = count;
    end
  end
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      count <= 32'h0000_0000;
    end else begin
      count <= next_count;
    end
  end
  assign o_expired = i_cond && (count >= LIMIT);
endmodule : persist_timer
`default_nettype wire

// ==== prox_encoder_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module prox_encoder_model (
  input wire logic i_ref_clk,
  input wire logic [5:0] i_open_mask,
  input wire logic [1:0] i_mode,
  output logic [5:0] o_track_ok,
  output logic o_prox_a_valid,
  output logic o_prox_b_valid,
  output logic o_freq_out_of_tol,
  output logic o_above_standstill
);
  // mode bit 0: frequencies apart, bit 1: switch b lost, below standstill
  initial begin
    o_track_ok = 6'h3F;
    o_prox_a_valid = 1'b1;
    o_prox_b_valid = 1'b1;
    o_freq_out_of_tol = 1'b0;
    o_above_standstill = 1'b1;
  end
  always @(posedge i_ref_clk) begin
    #1;
    o_track_ok <= ~i_open_mask;
    o_prox_b_valid <= ~i_mode[1];
    o_above_standstill <= ~i_mode[1];
    o_freq_out_of_tol <= i_mode[0];
  end
endmodule : prox_encoder_model
`default_nettype wire

// ==== speed_monitor_fault_supervisor_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "fault_supervisor_params.svh"
module speed_monitor_fault_supervisor_tb;
  import fault_supervisor_pkg::*;
  logic i_ref_clk = 0, i_rst = 1, i_start_input_terminal = 1;
  logic i_startup_ok = 1, i_root_cmd = 0, i_root_fb = 0;
  logic i_relay_output_one_fb = 0, i_relay_output_two_fb = 0;
  logic i_relay_output_one_cmd = 0, i_relay_output_two_cmd = 0;
  logic i_supply_vcc_fail = 0, i_supply_mid_fail = 0, i_volt_fault = 0;
  logic i_sync_start_sel = 0, i_analog_out_en = 0, i_error_out_fn = 0;
  logic [1:0] i_range_ok = 2'h3, i_image_local = 0, i_image_partner = 0;
  logic [1:0] mode = 0;
  logic [5:0] i_track_ok, open_mask = 0;
  logic [7:0] i_volt_mv_code = 0, o_error_param_high, o_error_param_low;
  logic i_prox_a_valid, i_prox_b_valid, i_freq_out_of_tol;
  logic i_above_standstill, o_fault_led, o_freq_warning;
  logic o_outputs_enable, o_follow_on;
  logic [1:0] o_range_ok;
  logic [15:0] o_error_code, o_track_mv;
  logic [15:0] codes[8] = '{`ERR_SUPPLY_VCC, `ERR_SUPPLY_MID, `ERR_IMAGE,
    `ERR_ROOT_RELAY, `ERR_RELAY_ONE, `ERR_RELAY_TWO, `ERR_SYNC_CONFLICT,
    `ERR_SYNC_CONFLICT};
  int miscompares = 0, compares = 0, cycles = 0;
  always #5 i_ref_clk = ~i_ref_clk;
  prox_encoder_model PARTNER (.i_ref_clk, .i_open_mask(open_mask),
    .i_mode(mode), .o_track_ok(i_track_ok), .o_prox_a_valid(i_prox_a_valid),
    .o_prox_b_valid(i_prox_b_valid), .o_freq_out_of_tol(i_freq_out_of_tol),
    .o_above_standstill(i_above_standstill));
  speed_monitor_fault_supervisor #(.DEV_CYCLES(20), .STOP_CYCLES(50)) DUT (
    .i_ref_clk, .i_rst, .i_track_ok, .i_prox_a_valid, .i_prox_b_valid,
    .i_freq_out_of_tol, .i_above_standstill, .i_start_input_terminal,
    .i_startup_ok, .i_range_ok, .i_image_local, .i_image_partner,
    .i_root_cmd, .i_root_fb, .i_relay_output_one_fb, .i_relay_output_two_fb,
    .i_relay_output_one_cmd, .i_relay_output_two_cmd, .i_supply_vcc_fail,
    .i_supply_mid_fail, .i_sync_start_sel, .i_analog_out_en, .i_error_out_fn,
    .i_volt_fault, .i_volt_mv_code, .o_fault_led, .o_freq_warning,
    .o_outputs_enable, .o_range_ok, .o_error_code, .o_follow_on,
    .o_error_param_high, .o_error_param_low, .o_track_mv);
  task automatic cyc(input int n);
    repeat (n) @(posedge i_ref_clk);
    #1;
  endtask : cyc
  task automatic chk(input string nm, input logic [15:0] exp, got);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic hard(input int k, input logic v);
    case (k)
      0: i_supply_vcc_fail = v;
      1: i_supply_mid_fail = v;
      2: i_image_partner = i_image_local ^ {1'b0, v};
      3: i_root_fb = i_root_cmd ^ v;
      4: i_relay_output_one_fb = i_relay_output_one_cmd ^ v;
      5: i_relay_output_two_fb = i_relay_output_two_cmd ^ v;
      6: {i_sync_start_sel, i_analog_out_en} = {v, v};
      default: {i_sync_start_sel, i_error_out_fn} = {v, v};
    endcase
  endtask : hard
  function automatic logic [15:0] mv(input logic [7:0] c);
    return 16'((32'(c) - 32'd170) * 32'd10000 / 32'd1204);
  endfunction : mv
  task automatic finish_test();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : finish_test
  always @(posedge i_ref_clk) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      finish_test();
    end
  end
  initial begin
    void'($urandom(55));
    cyc(8);
    i_rst = 0;
    {i_root_cmd, i_relay_output_one_cmd, i_relay_output_two_cmd} = 3'($urandom);
    {i_root_fb, i_relay_output_one_fb, i_relay_output_two_fb} =
      {i_root_cmd, i_relay_output_one_cmd, i_relay_output_two_cmd};
    i_image_local = 2'($urandom);
    i_image_partner = i_image_local;
    cyc(6);
    chk("code", `ERR_NONE, o_error_code);
    chk("enable", 1, o_outputs_enable);
    chk("led", 0, o_fault_led);
    $display("done idle");
    for (int k = 0; k < 8; k++) begin
      hard(k, 1);
      cyc(4);
      chk("code", codes[k], o_error_code);
      chk("enable", 0, o_outputs_enable);
      chk("follow", 1, o_follow_on);
      chk("led", 1, o_fault_led);
      hard(k, 0);
      i_startup_ok = 0;
      cyc(5);
      chk("enable", 0, o_outputs_enable);
      i_startup_ok = 1;
      cyc(4);
      chk("enable", 1, o_outputs_enable);
    end
    $display("done hard faults");
    for (int t = 0; t < 7; t++) begin
      open_mask = (t < 6) ? 6'(1 << t) : 6'($urandom | 1);
      cyc(6);
      chk("code", `ERR_SIGNAL, o_error_code);
      chk("enable", 0, o_outputs_enable);
      cyc(10);
      chk("code", `ERR_SIGNAL, o_error_code);
      open_mask = 0;
      cyc(6);
      chk("code", `ERR_NONE, o_error_code);
    end
    $display("done open circuit");
    for (int r = 0; r < 2; r++) begin
      mode = 3;
      cyc(10);
      chk("warn", 0, o_freq_warning);
      cyc(16);
      chk("warn", 1, o_freq_warning);
      chk("enable", 1, o_outputs_enable);
      chk("range", 0, o_range_ok);
      chk("led", 1, o_fault_led);
      cyc(34);
      chk("code", `ERR_FREQ_STOP, o_error_code);
      chk("enable", 0, o_outputs_enable);
      mode = r ? 2'h2 : 2'h0;
      cyc(6);
      if (r) begin
        chk("code", `ERR_FREQ_STOP, o_error_code);
        i_start_input_terminal = 0;
        cyc(6);
        mode = 0;
        i_start_input_terminal = 1;
      end
      chk("code", `ERR_NONE, o_error_code);
      cyc(6);
      chk("warn", 0, o_freq_warning);
      chk("led", 0, o_fault_led);
      chk("range", i_range_ok, o_range_ok);
    end
    $display("done frequency");
    i_volt_mv_code = 8'(170 + $urandom % 86);
    i_volt_fault = 1;
    cyc(3);
    i_volt_fault = 0;
    cyc(3);
    chk("high", 0, o_error_param_high);
    chk("low", i_volt_mv_code, o_error_param_low);
    chk("mv", mv(i_volt_mv_code), o_track_mv);
    $display("done voltage");
    finish_test();
  end
endmodule : speed_monitor_fault_supervisor_tb
`default_nettype wire
